// file: pkg/lp4c_pkg.sv
// Constants, carrier structs and state codes of the LPDDR4 controller.
// Assumes a 100 MHz core clock shared by register bus and AXI ports.
package lp4c_pkg;
  localparam int CLK_MHZ = 100;
  localparam int T_INIT_US = 200;
  localparam int INIT_CYC = T_INIT_US * CLK_MHZ;
  localparam int T_CKE_US = 2;
  localparam int CKE_CYC = T_CKE_US * CLK_MHZ;
  localparam int T_REFI_NS = 3900;
  localparam int REFI_CYC = T_REFI_NS * CLK_MHZ / 1000;
  localparam int T_RFC_NS = 180;
  localparam int RFC_CYC = (T_RFC_NS * CLK_MHZ + 999) / 1000;
  localparam int RL_CYC = 8;
  localparam int CA_CYC = 4;

  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [7:0] REG_QTH = 8'h08;
  localparam int CTRL_SREF = 0;
  localparam int CTRL_PD = 1;
  localparam int CTRL_REFOFF = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [7:0] QTH_RST = 8'h06;
  localparam int ST_DONE = 0;
  localparam int ST_IRQ = 1;
  localparam int ST_RBUSY = 2;
  localparam int ST_IDLE = 3;
  localparam int ST_REF = 4;
  localparam int ST_NFULL = 5;
  localparam int ST_CKE = 6;
  localparam int ST_QCNT = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [1:0] OP_WR = 2'h1;
  localparam logic [1:0] OP_RD = 2'h2;
  localparam logic [1:0] OP_REF = 2'h3;

  typedef enum logic [3:0] {
    S_RST = 4'h0, S_INIT = 4'h1, S_CKEW = 4'h2, S_IDLE = 4'h3,
    S_CA = 4'h4, S_WDAT = 4'h5, S_RWAIT = 4'h6, S_RDAT = 4'h7,
    S_REF = 4'h8, S_LOWP = 4'h9
  } lp4c_state_e;

  typedef struct packed {
    logic [5:0] id;
    logic [31:0] addr;
  } lp4c_addr_s;
  typedef struct packed {
    logic [31:0] data;
    logic [3:0] strb;
  } lp4c_wdat_s;
  typedef struct packed {
    logic [5:0] id;
    logic [1:0] resp;
  } lp4c_bresp_s;
  typedef struct packed {
    logic [5:0] id;
    logic [31:0] data;
    logic [1:0] resp;
    logic last;
  } lp4c_rdat_s;
  typedef struct packed {
    logic [1:0] op;
    logic port;
    logic [5:0] id;
    logic [21:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } lp4c_req_s;
endpackage

// file: test/lp4c_mem_model.sv
// Memory model on the data pins: keeps the last written word.
// Drives it back after each command, its inverse outside that window.
`timescale 1ns/1ps
module lp4c_mem_model (
  input wire logic aclk,
  input wire logic mem_reset_n,
  input wire logic [3:0] mem_cs_n,
  input wire logic [31:0] mem_dq_out,
  input wire logic [31:0] mem_dq_oe,
  output logic [31:0] mem_dq_in
);
  logic [31:0] word;
  logic [4:0] gap = 5'h1F;
  wire logic [31:0] drv = (gap > 5'h2 && gap < 5'h10) ? word : ~word;
  assign mem_dq_in = (mem_dq_oe & mem_dq_out) | (~mem_dq_oe & drv);
  always @(posedge aclk) begin
    if (!mem_reset_n) word <= '0;
    else if (|mem_dq_oe) word <= mem_dq_out;
    gap <= !mem_cs_n[0] ? 5'h0 : gap + 5'(gap != 5'h1F);
  end
endmodule

// file: test/lp4c_top_sva.sv
// Checker of memory pins, init handshake, status timing and reads.
// Assumes ctrl_clk has a period of 16 aclk cycles.
`timescale 1ns/1ps
module lp4c_top_sva import lp4c_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cfg_reset,
  input wire logic cfg_done,
  input wire logic ctrl_clk,
  input wire logic mem_reset_n,
  input wire logic mem_reset_valid,
  input wire logic mem_clock_out,
  input wire logic mem_clock_out_n,
  input wire logic [1:0] mem_cke,
  input wire logic [3:0] mem_cs_n,
  input wire logic refresh_active,
  input wire logic [1:0] cke_status,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic [1:0] s_axil_rresp
);
  logic [3:0] rcnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || cfg_reset) rcnt <= 4'h0;
    else if (rcnt != 4'hF) rcnt <= rcnt + 4'h1;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_bad_rd;
    s_axil_arvalid && s_axil_arready && s_axil_araddr > REG_QTH;
  endsequence
  sequence s_err_data;
    s_axil_rvalid && s_axil_rresp == RESP_SLVERR && s_axil_rdata == 32'h0;
  endsequence
  AST_SLVERR: assert property (s_bad_rd |=> s_err_data)
    else $error("unmapped read not refused");
  AST_RDONE: assert property (s_axil_rvalid && s_axil_rready |=> !s_axil_rvalid)
    else $error("read answer repeated");
  AST_STAT: assert property (rcnt == 4'hF && ($changed(refresh_active) ||
    $changed(cke_status)) |-> $past(ctrl_clk, 3) && !$past(ctrl_clk, 7))
    else $error("status changed off the status clock");
  AST_CFG_RST: assert property (cfg_reset |=>
    !cfg_done && !mem_reset_n && mem_cke == 2'h0)
    else $error("init reset ignored");
  AST_DONE: assert property (cfg_done |-> mem_reset_valid && mem_reset_n)
    else $error("done before memory reset released");
  AST_RSTV: assert property (mem_reset_valid |-> mem_reset_n)
    else $error("reset valid while memory held in reset");
  AST_CS: assert property (mem_cs_n[3:1] == 3'h7)
    else $error("unused chip select driven");
  AST_CK: assert property (mem_clock_out_n == !mem_clock_out)
    else $error("memory clock pair not complementary");
endmodule
bind lp4c_top lp4c_top_sva i_sva (.*);

// file: test/test_lp4c_top.sv
// Bench: register bus, init handshake, port traffic and status outputs.
// Assumes the memory model on the data pins and the bound checker.
`timescale 1ns/1ps
module test_lp4c_top import lp4c_pkg::*; ;
  logic aclk = 0, aresetn = 0, ctrl_clk = 0, cfg_reset = 0, cfg_start = 0;
  logic cfg_sel = 1'b0;
  logic cfg_done, mem_reset_n, mem_reset_valid, ctrl_interrupt;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
  logic s_axil_arvalid = 0, s_axil_rready = 0, s_axil_awready, s_axil_wready;
  logic s_axil_bvalid, s_axil_arready, s_axil_rvalid, mem_clock_out;
  logic mem_clock_out_n, refresh_active, ctrl_read_busy, datapath_idle;
  logic cmd_queue_near_full;
  logic [1:0] s_axil_bresp, s_axil_rresp, mem_cke, cke_status, port_read_busy;
  logic [1:0] axi_port_reset_n = '0, p_awvalid = '0, p_wvalid = '0;
  logic [1:0] p_bready = '0, p_arvalid = '0, p_rready = '0, p_awready;
  logic [1:0] p_wready, p_bvalid, p_arready, p_rvalid;
  logic [3:0] s_axil_wstrb = 4'hF, mem_cs_n, mem_dqs_in = '0, mem_dqs_out;
  logic [3:0] mem_dqs_n_out, mem_dqs_oe, mem_data_mask_in = '0, mem_data_mask;
  logic [3:0] mem_data_mask_oe;
  logic [5:0] mem_ca;
  logic [7:0] s_axil_awaddr = '0, s_axil_araddr = '0;
  logic [31:0] s_axil_wdata = '0, s_axil_rdata, mem_dq_in, mem_dq_out;
  logic [31:0] mem_dq_oe;
  lp4c_addr_s [1:0] p_aw = '0, p_ar = '0;
  lp4c_wdat_s [1:0] p_w = '0;
  lp4c_bresp_s [1:0] p_b;
  lp4c_rdat_s [1:0] p_r;
  int err_count = 0, checks = 0;
  lp4c_top #(.DQ_W(32), .INIT_CYCLES(50)) i_dut (.*);
  lp4c_mem_model i_mem (.*);
  always #5 aclk = ~aclk;
  always #80 ctrl_clk = ~ctrl_clk;
  task automatic close_out();
    if (err_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask
  task automatic need(logic ok);
    chk("handshake", 32'h1, 32'(ok));
    if (ok !== 1'b1) close_out();
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic lite(logic wr, logic [7:0] a, logic [31:0] d, logic [1:0] rs);
    int n = 0;
    s_axil_awaddr <= a;
    s_axil_araddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= wr;
    s_axil_wvalid <= wr;
    s_axil_arvalid <= !wr;
    s_axil_bready <= wr;
    s_axil_rready <= !wr;
    do begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
    end while (!(wr ? s_axil_bvalid : s_axil_rvalid) && ++n < 99);
    need(wr ? s_axil_bvalid : s_axil_rvalid);
    chk("resp", 32'(rs), wr ? 32'(s_axil_bresp) : 32'(s_axil_rresp));
    if (!wr) chk("rdata", d, s_axil_rdata);
    cyc(1);
  endtask
  task automatic prw(int p, logic [31:0] d);
    int n = 0;
    p_aw[p] <= '{id: 6'h05, addr: 32'h40 << p};
    p_ar[p] <= '{id: 6'h05, addr: 32'h40 << p};
    p_w[p] <= '{data: d, strb: 4'hF};
    p_awvalid[p] <= 1'b1;
    p_wvalid[p] <= 1'b1;
    p_bready[p] <= 1'b1;
    do begin
      @(posedge aclk);
      if (p_awready[p]) p_awvalid[p] <= 1'b0;
      if (p_wready[p]) p_wvalid[p] <= 1'b0;
    end while (!p_bvalid[p] && ++n < 300);
    need(p_bvalid[p]);
    p_bready[p] <= 1'b0;
    chk("bresp", 32'h0, 32'(p_b[p].resp));
    p_arvalid[p] <= 1'b1;
    p_rready[p] <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (p_arready[p]) p_arvalid[p] <= 1'b0;
    end while (!p_rvalid[p] && ++n < 300);
    need(p_rvalid[p]);
    p_rready[p] <= 1'b0;
    chk("rdata", d, p_r[p].data);
    chk("rlast_id", 32'h45, 32'({p_r[p].last, p_r[p].id}));
  endtask
  task automatic t_boot();
    chk("cfg_done", 32'h0, 32'(cfg_done));
    chk("mem_reset_n", 32'h0, 32'(mem_reset_n));
    lite(1'b0, REG_QTH, 32'(QTH_RST), RESP_OKAY);
    lite(1'b0, 8'h10, 32'h0, RESP_SLVERR);
    lite(1'b1, 8'h10, 32'h0, RESP_SLVERR);
  endtask
  task automatic t_init();
    int n = 0;
    cfg_start <= 1'b1;
    cyc(1);
    cfg_start <= 1'b0;
    while (!cfg_done && ++n < 999) cyc(1);
    need(cfg_done);
    chk("reset_valid", 32'h1, 32'(mem_reset_valid));
    chk("cke", 32'h3, 32'(mem_cke));
    cyc(40);
    chk("cke_status", 32'h3, 32'(cke_status));
  endtask
  task automatic t_port();
    lite(1'b1, REG_CTRL, 32'h4, RESP_OKAY);
    for (int p = 0; p < 2; p++) prw(p, 32'hA5C3_0F10 ^ 32'(p));
    cyc(40);
    chk("idle", 32'h1, 32'(datapath_idle));
    chk("read_busy", 32'h0, 32'(ctrl_read_busy));
    chk("port_busy", 32'h0, 32'(port_read_busy));
    chk("refresh", 32'h0, 32'(refresh_active));
    chk("near_full", 32'h0, 32'(cmd_queue_near_full));
    chk("irq", 32'h0, 32'(ctrl_interrupt));
  endtask
  task automatic t_lowp();
    int n = 0;
    lite(1'b1, REG_CTRL, 32'h5, RESP_OKAY);
    cyc(60);
    chk("cke", 32'h0, 32'(mem_cke));
    chk("cke_status", 32'h0, 32'(cke_status));
    lite(1'b1, REG_CTRL, 32'h0, RESP_OKAY);
    cyc(60);
    chk("cke_status", 32'h3, 32'(cke_status));
    while (!refresh_active && ++n < 999) cyc(1);
    chk("refresh", 32'h1, 32'(refresh_active));
  endtask
  task automatic t_rst();
    lite(1'b1, REG_QTH, 32'h3, RESP_OKAY);
    cfg_reset <= 1'b1;
    cyc(2);
    cfg_reset <= 1'b0;
    chk("cfg_done", 32'h0, 32'(cfg_done));
    chk("mem_reset_n", 32'h0, 32'(mem_reset_n));
    lite(1'b0, REG_QTH, 32'h3, RESP_OKAY);
    t_init();
    prw(0, 32'h1234_5678);
  endtask
  initial begin
    cyc(3);
    aresetn <= 1'b1;
    axi_port_reset_n <= 2'h3;
    cyc(1);
    t_boot();
    t_init();
    t_port();
    t_lowp();
    t_rst();
    close_out();
  end
endmodule

// file: verilog/lp4c_top.sv
// LPDDR4 controller: two AXI4 ports, command queue, memory pin sequencer,
// status outputs on the sampled status clock, init handshake, AXI4-Lite.
// Assumes fabric inputs and AXI ports run on aclk; ctrl_clk and mem_dq_in
// arrive from outside and are synchronised here.
// Behaviour
// - Works LPDDR4/LPDDR4x memories with 16 or 32 data lines.
// - Two independent full-duplex AXI4 ports carry all memory traffic.
// - The PHY pins are reached only through this controller.
// - Data bus top index 15 or 31; driven on writes, memory on reads.
// - One strobe pair and one active-high mask bit per byte lane.
// - Drives active-low reset, two clock enables, four chip selects.
// - Drives six-bit command/address bus and differential memory clock.
// - Refresh-active status high while a refresh command executes.
// - Two-bit status shows delayed copy of internal clock enable.
// - Read-busy while reading; datapath-idle when idle; status clocked.
// - Per-port busy bit while that port is reading.
// - Queue near-full once occupancy reaches the configured threshold.
// - Interrupt and reset-done outputs have no status clock timing.
// - Init reset clears controller, PHY and memory; config registers keep their values.
// - Init done asserts when the configuration sequence finishes.
`timescale 1ns/1ps
module lp4c_top import lp4c_pkg::*; #(
  parameter int DQ_W = 32,
  parameter int QDEPTH = 8,
  parameter int INIT_CYCLES = INIT_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [7:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [1:0] axi_port_reset_n,
  input wire logic [1:0] p_awvalid,
  input wire lp4c_addr_s [1:0] p_aw,
  output logic [1:0] p_awready,
  input wire logic [1:0] p_wvalid,
  input wire lp4c_wdat_s [1:0] p_w,
  output logic [1:0] p_wready,
  output logic [1:0] p_bvalid,
  output lp4c_bresp_s [1:0] p_b,
  input wire logic [1:0] p_bready,
  input wire logic [1:0] p_arvalid,
  input wire lp4c_addr_s [1:0] p_ar,
  output logic [1:0] p_arready,
  output logic [1:0] p_rvalid,
  output lp4c_rdat_s [1:0] p_r,
  input wire logic [1:0] p_rready,
  output logic mem_clock_out,
  output logic mem_clock_out_n,
  output logic mem_reset_n,
  output logic [1:0] mem_cke,
  output logic [3:0] mem_cs_n,
  output logic [5:0] mem_ca,
  input wire logic [DQ_W-1:0] mem_dq_in,
  output logic [DQ_W-1:0] mem_dq_out,
  output logic [DQ_W-1:0] mem_dq_oe,
  input wire logic [DQ_W/8-1:0] mem_dqs_in,
  output logic [DQ_W/8-1:0] mem_dqs_out,
  output logic [DQ_W/8-1:0] mem_dqs_n_out,
  output logic [DQ_W/8-1:0] mem_dqs_oe,
  input wire logic [DQ_W/8-1:0] mem_data_mask_in,
  output logic [DQ_W/8-1:0] mem_data_mask,
  output logic [DQ_W/8-1:0] mem_data_mask_oe,
  input wire logic ctrl_clk,
  output logic ctrl_interrupt,
  output logic mem_reset_valid,
  output logic refresh_active,
  output logic [1:0] cke_status,
  output logic ctrl_read_busy,
  output logic datapath_idle,
  output logic [1:0] port_read_busy,
  output logic cmd_queue_near_full,
  input wire logic cfg_reset,
  input wire logic cfg_start,
  input wire logic cfg_sel,
  output logic cfg_done
);
  localparam int LANES = DQ_W / 8;
  localparam int BEATS = 32 / DQ_W;
  localparam int QAW = $clog2(QDEPTH);

  // Config reset clears controller, PHY sequencer and memory reset pin
  wire rst = ~aresetn | cfg_reset;

  lp4c_state_e st_reg;
  logic [14:0] cnt_reg;
  lp4c_req_s cur_reg;
  logic [23:0] ca_sh_reg;
  logic [31:0] d_sh_reg, rd_sh_reg;
  logic [3:0] m_sh_reg;
  logic eng_done_reg, done_reg, rstv_reg, irq_reg, ref_due_reg;
  logic [9:0] refi_reg;
  logic [DQ_W-1:0] dq_s1_reg, dq_s2_reg;
  logic ck_s1_reg, ck_s2_reg, ck_s3_reg;
  logic [2:0] ctrl_reg;
  logic [QAW:0] qth_reg, q_cnt_reg;
  logic [QAW-1:0] q_wp_reg, q_rp_reg;
  lp4c_req_s q_mem [QDEPTH];
  logic rr_reg;

  // Command queue
  wire q_empty = q_cnt_reg == '0;
  wire q_full = q_cnt_reg == (QAW+1)'(QDEPTH);
  wire run = done_reg;
  wire go_ref = ref_due_reg & ~ctrl_reg[CTRL_REFOFF];
  wire go_low = ctrl_reg[CTRL_SREF] | ctrl_reg[CTRL_PD];
  wire pop = (st_reg == S_IDLE) & ~go_ref & ~go_low & ~q_empty;

  // Per-port holders and arbitration
  logic aw_full_reg [2], w_full_reg [2], ar_full_reg [2];
  logic wr_pend_reg [2], rd_pend_reg [2];
  lp4c_addr_s aw_reg [2], ar_reg [2];
  lp4c_wdat_s w_reg [2];
  logic [1:0] wr_req, rd_req;
  wire pa = (wr_req[rr_reg] | rd_req[rr_reg]) ? rr_reg : ~rr_reg;
  wire pick_wr = wr_req[pa];
  wire push = (wr_req[pa] | rd_req[pa]) & ~q_full;
  lp4c_req_s push_req;
  always_comb begin
    push_req.op = pick_wr ? OP_WR : OP_RD;
    push_req.port = pa;
    push_req.id = pick_wr ? aw_reg[pa].id : ar_reg[pa].id;
    push_req.addr = pick_wr ? aw_reg[pa].addr[23:2] : ar_reg[pa].addr[23:2];
    push_req.data = w_reg[pa].data;
    push_req.strb = pick_wr ? w_reg[pa].strb : 4'h0;
  end

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_port
      logic awr_reg, wr_reg, arr_reg, bv_reg, rv_reg;
      lp4c_bresp_s b_reg;
      lp4c_rdat_s r_reg;
      wire prst = rst | ~axi_port_reset_n[g];
      wire aw_hs = p_awvalid[g] & awr_reg;
      wire w_hs = p_wvalid[g] & wr_reg;
      wire ar_hs = p_arvalid[g] & arr_reg;
      wire my_done = eng_done_reg & (cur_reg.port == 1'(g));
      wire wr_push = push & (pa == 1'(g)) & pick_wr;
      wire rd_push = push & (pa == 1'(g)) & ~pick_wr;
      assign wr_req[g] = aw_full_reg[g] & w_full_reg[g] & ~wr_pend_reg[g];
      assign rd_req[g] = ar_full_reg[g] & ~rd_pend_reg[g];
      assign p_awready[g] = awr_reg;
      assign p_wready[g] = wr_reg;
      assign p_arready[g] = arr_reg;
      assign p_bvalid[g] = bv_reg;
      assign p_b[g] = b_reg;
      assign p_rvalid[g] = rv_reg;
      assign p_r[g] = r_reg;
      always_ff @(posedge aclk) begin
        if (prst) begin
          {awr_reg, wr_reg, arr_reg, bv_reg, rv_reg} <= 5'h00;
          aw_full_reg[g] <= 1'b0;
          w_full_reg[g] <= 1'b0;
          ar_full_reg[g] <= 1'b0;
          wr_pend_reg[g] <= 1'b0;
          rd_pend_reg[g] <= 1'b0;
          b_reg <= '0;
          r_reg <= '0;
          aw_reg[g] <= '0;
          ar_reg[g] <= '0;
          w_reg[g] <= '0;
        end else begin
          // Ports accept traffic only after init done
          awr_reg <= run & ~aw_hs & ~aw_full_reg[g] & ~wr_pend_reg[g];
          wr_reg <= run & ~w_hs & ~w_full_reg[g] & ~wr_pend_reg[g];
          arr_reg <= run & ~ar_hs & ~ar_full_reg[g] & ~rd_pend_reg[g];
          if (aw_hs) begin
            aw_full_reg[g] <= 1'b1;
            aw_reg[g] <= p_aw[g];
          end
          if (w_hs) begin
            w_full_reg[g] <= 1'b1;
            w_reg[g] <= p_w[g];
          end
          if (ar_hs) begin
            ar_full_reg[g] <= 1'b1;
            ar_reg[g] <= p_ar[g];
          end
          if (wr_push) begin
            aw_full_reg[g] <= 1'b0;
            w_full_reg[g] <= 1'b0;
            wr_pend_reg[g] <= 1'b1;
          end
          if (rd_push) begin
            ar_full_reg[g] <= 1'b0;
            rd_pend_reg[g] <= 1'b1;
          end
          if (my_done & (cur_reg.op == OP_WR)) begin
            bv_reg <= 1'b1;
            b_reg <= '{id: cur_reg.id, resp: RESP_OKAY};
          end else if (bv_reg & p_bready[g]) begin
            bv_reg <= 1'b0;
            wr_pend_reg[g] <= 1'b0;
          end
          if (my_done & (cur_reg.op == OP_RD)) begin
            rv_reg <= 1'b1;
            r_reg <= '{id: cur_reg.id, data: rd_sh_reg,
                       resp: RESP_OKAY, last: 1'b1};
          end else if (rv_reg & p_rready[g]) begin
            rv_reg <= 1'b0;
            rd_pend_reg[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // Read and write requests from both ports share one queue; refresh commands bypass it
  always_ff @(posedge aclk) begin
    if (push) begin
      q_mem[q_wp_reg] <= push_req;
    end
  end
  always_ff @(posedge aclk) begin
    if (rst) begin
      q_wp_reg <= '0;
      q_rp_reg <= '0;
      q_cnt_reg <= '0;
      rr_reg <= 1'b0;
    end else begin
      if (push) begin
        q_wp_reg <= q_wp_reg + 1'b1;
        rr_reg <= ~pa;
      end
      if (pop) begin
        q_rp_reg <= q_rp_reg + 1'b1;
      end
      q_cnt_reg <= q_cnt_reg + (QAW+1)'(push) - (QAW+1)'(pop);
    end
  end

  // Refresh interval timer
  always_ff @(posedge aclk) begin
    if (rst | ~run) begin
      refi_reg <= 10'(REFI_CYC - 1);
      ref_due_reg <= 1'b0;
    end else begin
      refi_reg <= (refi_reg == '0) ? 10'(REFI_CYC - 1) : refi_reg - 1'b1;
      if (refi_reg == '0) begin
        ref_due_reg <= 1'b1;
      end else if (st_reg == S_IDLE & go_ref) begin
        ref_due_reg <= 1'b0;
      end
    end
  end

  // Memory sequencer
  always_ff @(posedge aclk) begin
    if (rst) begin
      st_reg <= S_RST;
      cnt_reg <= '0;
      cur_reg <= '0;
      ca_sh_reg <= '0;
      d_sh_reg <= '0;
      m_sh_reg <= '0;
      rd_sh_reg <= '0;
      eng_done_reg <= 1'b0;
      done_reg <= 1'b0;
      rstv_reg <= 1'b0;
    end else begin
      eng_done_reg <= 1'b0;
      case (st_reg)
        S_RST: begin
          if (cfg_start & ~cfg_sel) begin
            st_reg <= S_INIT;
            cnt_reg <= 15'(INIT_CYCLES - 1);
          end
        end
        S_INIT: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            st_reg <= S_CKEW;
            cnt_reg <= 15'(CKE_CYC - 1);
            rstv_reg <= 1'b1;
          end
        end
        S_CKEW: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            st_reg <= S_IDLE;
            done_reg <= 1'b1;
          end
        end
        S_IDLE: begin
          cnt_reg <= 15'(CA_CYC - 1);
          if (go_ref) begin
            st_reg <= S_CA;
            cur_reg <= '{op: OP_REF, default: '0};
            ca_sh_reg <= 24'(OP_REF);
          end else if (go_low) begin
            st_reg <= S_LOWP;
          end else if (~q_empty) begin
            st_reg <= S_CA;
            cur_reg <= q_mem[q_rp_reg];
            ca_sh_reg <= {q_mem[q_rp_reg].addr, q_mem[q_rp_reg].op};
            d_sh_reg <= q_mem[q_rp_reg].data;
            m_sh_reg <= q_mem[q_rp_reg].strb;
          end
        end
        S_CA: begin
          ca_sh_reg <= ca_sh_reg >> 6;
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            case (cur_reg.op)
              OP_WR: begin
                st_reg <= S_WDAT;
                cnt_reg <= 15'(BEATS - 1);
              end
              OP_RD: begin
                st_reg <= S_RWAIT;
                cnt_reg <= 15'(RL_CYC - 1);
              end
              default: begin
                st_reg <= S_REF;
                cnt_reg <= 15'(RFC_CYC - 1);
              end
            endcase
          end
        end
        S_WDAT: begin
          d_sh_reg <= 32'({8'h00, d_sh_reg} >> DQ_W);
          m_sh_reg <= 4'({4'h0, m_sh_reg} >> LANES);
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            st_reg <= S_IDLE;
            eng_done_reg <= 1'b1;
          end
        end
        S_RWAIT: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            st_reg <= S_RDAT;
            cnt_reg <= 15'(BEATS - 1);
          end
        end
        S_RDAT: begin
          rd_sh_reg <= 32'({dq_s2_reg, rd_sh_reg} >> DQ_W);
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            st_reg <= S_IDLE;
            eng_done_reg <= 1'b1;
          end
        end
        S_REF: begin
          cnt_reg <= cnt_reg - 1'b1;
          if (cnt_reg == '0) begin
            st_reg <= S_IDLE;
          end
        end
        S_LOWP: begin
          if (~go_low) begin
            st_reg <= S_IDLE;
          end
        end
        default: st_reg <= S_RST;
      endcase
    end
  end

  // Pin drive, one cycle behind the sequencer
  wire cke_on = ~(st_reg inside {S_RST, S_INIT, S_CKEW, S_LOWP});
  wire wdat = st_reg == S_WDAT;
  wire [LANES-1:0] dqs_nx = wdat ? ~mem_dqs_out : '0;
  wire ref_now = (st_reg == S_REF) |
                 ((st_reg == S_CA) & (cur_reg.op == OP_REF));
  wire rbusy = (st_reg inside {S_RWAIT, S_RDAT}) |
               ((st_reg == S_CA) & (cur_reg.op == OP_RD));
  always_ff @(posedge aclk) begin
    if (rst) begin
      mem_clock_out <= 1'b0;
      mem_clock_out_n <= 1'b1;
      mem_reset_n <= 1'b0;
      mem_cke <= 2'h0;
      mem_cs_n <= 4'hF;
      mem_ca <= 6'h00;
      mem_dq_out <= '0;
      mem_dq_oe <= '0;
      mem_dqs_out <= '0;
      mem_dqs_n_out <= '1;
      mem_dqs_oe <= '0;
      mem_data_mask <= '0;
      mem_data_mask_oe <= '0;
    end else begin
      mem_clock_out <= ~mem_clock_out;
      mem_clock_out_n <= mem_clock_out;
      mem_reset_n <= ~(st_reg inside {S_RST, S_INIT});
      mem_cke <= cke_on ? 2'h3 : 2'h0;
      mem_cs_n <= (st_reg == S_CA) ? 4'hE : 4'hF;
      mem_ca <= (st_reg == S_CA) ? ca_sh_reg[5:0] : 6'h00;
      mem_dq_out <= d_sh_reg[DQ_W-1:0];
      mem_dq_oe <= {DQ_W{wdat}};
      mem_dqs_out <= dqs_nx;
      mem_dqs_n_out <= ~dqs_nx;
      mem_dqs_oe <= {LANES{wdat}};
      mem_data_mask <= ~m_sh_reg[LANES-1:0];
      mem_data_mask_oe <= {LANES{wdat}};
    end
  end

  // Synchronisers for outside inputs
  always_ff @(posedge aclk) begin
    dq_s1_reg <= mem_dq_in;
    dq_s2_reg <= dq_s1_reg;
    ck_s1_reg <= ctrl_clk;
    ck_s2_reg <= ck_s1_reg;
    ck_s3_reg <= ck_s2_reg;
  end
  wire ck_rise = ck_s2_reg & ~ck_s3_reg;

  // Status outputs move only on status clock rising edges
  always_ff @(posedge aclk) begin
    if (rst) begin
      refresh_active <= 1'b0;
      cke_status <= 2'h0;
      ctrl_read_busy <= 1'b0;
      datapath_idle <= 1'b0;
      port_read_busy <= 2'h0;
      cmd_queue_near_full <= 1'b0;
    end else if (ck_rise) begin
      refresh_active <= ref_now;
      cke_status <= mem_cke;
      ctrl_read_busy <= rbusy;
      datapath_idle <= (st_reg == S_IDLE) & q_empty;
      port_read_busy <= {rd_pend_reg[1], rd_pend_reg[0]};
      cmd_queue_near_full <= q_cnt_reg >= qth_reg;
    end
  end

  // Register bus
  logic la_full_reg, lw_full_reg;
  logic [7:0] la_addr_reg;
  logic [31:0] lw_data_reg;
  logic [3:0] lw_strb_reg;
  logic [31:0] stat_word;
  wire l_aw_hs = s_axil_awvalid & s_axil_awready;
  wire l_w_hs = s_axil_wvalid & s_axil_wready;
  wire l_ar_hs = s_axil_arvalid & s_axil_arready;
  wire do_wr = la_full_reg & lw_full_reg & ~s_axil_bvalid;
  wire wr_ctrl = do_wr & (la_addr_reg == REG_CTRL) & lw_strb_reg[0];
  wire wr_stat = do_wr & (la_addr_reg == REG_STAT) & lw_strb_reg[0];
  wire wr_qth = do_wr & (la_addr_reg == REG_QTH) & lw_strb_reg[0];
  wire wr_hit = la_addr_reg inside {REG_CTRL, REG_STAT, REG_QTH};
  wire rd_hit = s_axil_araddr inside {REG_CTRL, REG_STAT, REG_QTH};
  wire irq_set = (|(wr_req | rd_req)) & q_full;
  always_comb begin
    stat_word = '0;
    stat_word[ST_DONE] = done_reg;
    stat_word[ST_IRQ] = irq_reg;
    stat_word[ST_RBUSY] = rbusy;
    stat_word[ST_IDLE] = (st_reg == S_IDLE) & q_empty;
    stat_word[ST_REF] = ref_now;
    stat_word[ST_NFULL] = q_cnt_reg >= qth_reg;
    stat_word[ST_CKE +: 2] = mem_cke;
    stat_word[ST_QCNT +: QAW+1] = q_cnt_reg;
  end
  wire [31:0] rd_mux = (s_axil_araddr == REG_CTRL) ? 32'(ctrl_reg) :
                       (s_axil_araddr == REG_STAT) ? stat_word :
                       (s_axil_araddr == REG_QTH) ? 32'(qth_reg) : 32'h0;

  always_ff @(posedge aclk) begin
    if (~aresetn) begin
      {s_axil_awready, s_axil_wready, s_axil_arready} <= 3'h0;
      {s_axil_bvalid, s_axil_rvalid} <= 2'h0;
      s_axil_bresp <= RESP_OKAY;
      s_axil_rresp <= RESP_OKAY;
      s_axil_rdata <= '0;
      la_full_reg <= 1'b0;
      lw_full_reg <= 1'b0;
      la_addr_reg <= '0;
      lw_data_reg <= '0;
      lw_strb_reg <= '0;
      ctrl_reg <= CTRL_RST;
      qth_reg <= (QAW+1)'(QTH_RST);
    end else begin
      s_axil_awready <= ~l_aw_hs & ~la_full_reg;
      s_axil_wready <= ~l_w_hs & ~lw_full_reg;
      s_axil_arready <= ~l_ar_hs & ~s_axil_rvalid;
      if (l_aw_hs) begin
        la_full_reg <= 1'b1;
        la_addr_reg <= s_axil_awaddr;
      end
      if (l_w_hs) begin
        lw_full_reg <= 1'b1;
        lw_data_reg <= s_axil_wdata;
        lw_strb_reg <= s_axil_wstrb;
      end
      if (do_wr) begin
        la_full_reg <= 1'b0;
        lw_full_reg <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl_reg <= lw_data_reg[2:0];
      end
      if (wr_qth) begin
        qth_reg <= lw_data_reg[QAW:0];
      end
      if (l_ar_hs) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rdata <= rd_mux;
        s_axil_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end
  end

  // Clockless flags: interrupt and reset-done; set wins over clear
  always_ff @(posedge aclk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else if (irq_set) begin
      irq_reg <= 1'b1;
    end else if (wr_stat & lw_data_reg[ST_IRQ]) begin
      irq_reg <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    ctrl_interrupt <= ~rst & (irq_reg | irq_set);
    mem_reset_valid <= ~rst & rstv_reg;
    cfg_done <= ~rst & done_reg;
  end
endmodule
